/* design/etsc_edge_det.sv */
/*
  two-flop synchroniser and rising edge detector for the external event pin.
  assumes the pin is asynchronous to i_ref_clk and slow next to it.
*/
`timescale 1ns/1ps
`default_nettype none
module etsc_edge_det (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // pin side
  input wire logic i_pin,
  // synchronous side
  output logic o_level,
  output logic o_rise
);
  import etsc_pkg::*;

  logic meta_r;
  logic sync_r;
  etsc_pin_st_t st_r;
  etsc_pin_st_t st_nxt;

  // ---------------------------------------------------------------
  // synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= i_pin;
      sync_r <= meta_r;
    end
  end

  // ---------------------------------------------------------------
  // edge state
  // ---------------------------------------------------------------
  always_comb begin
    case (st_r)
      ETSC_PIN_IDLE: st_nxt = sync_r ? ETSC_PIN_SEEN : ETSC_PIN_IDLE;
      ETSC_PIN_SEEN: st_nxt = sync_r ? ETSC_PIN_HIGH : ETSC_PIN_IDLE;
      ETSC_PIN_HIGH: st_nxt = sync_r ? ETSC_PIN_HIGH : ETSC_PIN_IDLE;
      default: st_nxt = ETSC_PIN_IDLE;
    endcase
  end

  // reset state is high, but sync_r resets low so the state drops to idle and a pin already high at release still gives a rise
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st_r <= ETSC_PIN_HIGH;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_level = sync_r;
  assign o_rise = (st_r == ETSC_PIN_SEEN);
endmodule
`default_nettype wire

/* design/etsc_pkg.sv */
/*
  shared types and constants of the event time stamp capture block.
  assumes the surrounding clock/calendar core presents its time as a packed struct
  and that the register interface hands over decoded strobes on the same clock.
*/
// What this block does
// - high overwrite bit selects last or first
// - high first capture only when bank zero
// - high counter counts every high event while stamp enable set
// - high clear zeroes bank, flag; reads zero
// - host read of high bank blocks capture
// - status write clears high and low flags
// - sync actions give no extra second tick
// - event function off in backup supply
// - external event copies time into bank
// - event overwrite bit selects last or first
// - event counter counts every event
// - each written one clears event bank once
// - event clear leaves event flag alone
// - event first decision uses counter zero
// - power-on clears event bank if pin high
// - sync: stamp, clear hundredths, drop enable
// - stop halts tick, hundredths held zero
// - seconds write or sync zeroes hundredths
// - event sets flag; irq gated by enable
// - host read of event bank blocks capture
// - high event when reading top exceeds threshold
// - high capture only with stamp enable set
package etsc_pkg;

  // ---------------------------------------------------------------
  // time and bank layout
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] hundredths;
    logic [7:0] seconds;
    logic [7:0] minutes;
    logic [7:0] hours;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
  } etsc_time_t;

  typedef struct packed {
    logic [7:0] count;
    etsc_time_t stamp;
  } etsc_bank_t;

  localparam int ETSC_BYTE_W = 8;
  localparam logic [7:0] ETSC_ZERO_BYTE = 8'h00;
  localparam logic [7:0] ETSC_ONE_BYTE = 8'h01;
  localparam etsc_bank_t ETSC_BANK_CLEAR = '0;

  // thermometer reading and the slice compared against the threshold
  localparam int ETSC_TEMP_W = 12;
  localparam int ETSC_TEMP_HI = 11;
  localparam int ETSC_TEMP_LO = 4;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int ETSC_CLK_HZ = 40_000_000;
  localparam int ETSC_HUNDREDTH_HZ = 100;
  localparam int ETSC_HUNDREDTH_CYC = ETSC_CLK_HZ / ETSC_HUNDREDTH_HZ;
  localparam int ETSC_HUNDREDTHS_PER_S = 100;
  // settle cycles of the event pin filter after power-on
  localparam int ETSC_POR_SAMPLE_CYC = 4;

  // external pin edge detector state
  typedef enum logic [1:0] {
    ETSC_PIN_IDLE = 2'b00,
    ETSC_PIN_HIGH = 2'b01,
    ETSC_PIN_SEEN = 2'b10
  } etsc_pin_st_t;

endpackage

/* design/etsc_stamp_bank.sv */
/*
  one time stamp bank: event counter plus captured time.
  assumes capture and clear arrive as single-cycle strobes and block as a level on i_ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module etsc_stamp_bank #(
  parameter bit COUNT_ONLY_FIRST = 1'b0
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_event,
  input wire logic i_overwrite,
  input wire logic i_block,
  input wire logic i_clear,
  input wire etsc_pkg::etsc_time_t i_time,
  // bank contents
  output etsc_pkg::etsc_bank_t o_bank
);
  import etsc_pkg::*;

  etsc_bank_t bank_r;
  logic first_ok;

  // the event bank decides on the counter alone; the high bank needs all zero
  assign first_ok = COUNT_ONLY_FIRST ? (bank_r.count == ETSC_ZERO_BYTE)
                                     : (bank_r == ETSC_BANK_CLEAR);

  // ---------------------------------------------------------------
  // bank update
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      bank_r <= ETSC_BANK_CLEAR;
    end else if (i_clear) begin
      bank_r <= ETSC_BANK_CLEAR;
    end else if (i_event) begin
      // counter wraps at its width and counts even when blocked
      bank_r.count <= bank_r.count + ETSC_ONE_BYTE;
      if (!i_block && (i_overwrite || first_ok)) begin
        bank_r.stamp <= i_time;
      end
    end
  end

  assign o_bank = bank_r;
endmodule
`default_nettype wire

/* design/etsc_top.sv */
/*
  event time stamp capture: high temperature and external event banks,
  hundredths counter with resync, flags and interrupt request.
  assumes the host register logic supplies one-cycle write strobes, a level
  while a bank is being read, and receives the banks and flags as ports.
  the seconds and calendar registers live outside and arrive on i_time.
*/
`timescale 1ns/1ps
`default_nettype none
module etsc_top #(
  parameter int HUNDREDTH_CYC = etsc_pkg::ETSC_HUNDREDTH_CYC
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // time from the calendar core
  input wire etsc_pkg::etsc_time_t i_time,
  input wire logic i_stop,
  input wire logic i_seconds_wr,
  // thermometer
  input wire logic i_meas_done,
  input wire logic [etsc_pkg::ETSC_TEMP_W-1:0] i_temp,
  input wire logic [7:0] i_high_threshold,
  input wire logic i_high_stamp_enable,
  // high bank control
  input wire logic i_high_stamp_overwrite,
  input wire logic i_high_stamp_clear_wr,
  input wire logic i_high_bank_rd,
  // low flag set from the low comparator outside
  input wire logic i_low_temp_event,
  // status write strobe
  input wire logic i_status_wr,
  input wire logic i_high_flag_clr,
  input wire logic i_event_flag_clr,
  // event bank control
  input wire logic i_external_event_pin,
  input wire logic i_backup_supply_state,
  input wire logic i_event_stamp_overwrite,
  input wire logic i_event_stamp_clear_wr,
  input wire logic i_event_stamp_clear_val,
  input wire logic i_event_bank_rd,
  input wire logic i_event_sync_enable_wr,
  input wire logic i_event_sync_enable_val,
  input wire logic i_event_irq_enable,
  // banks
  output etsc_pkg::etsc_bank_t o_high_bank,
  output etsc_pkg::etsc_bank_t o_event_bank,
  output logic [7:0] o_hundredths,
  // status
  output logic o_high_temp_flag,
  output logic o_low_temp_flag,
  output logic o_external_event_flag,
  output logic o_event_sync_enable,
  output logic o_event_stamp_clear,
  output logic o_high_stamp_clear,
  output logic o_second_tick,
  output logic o_irq_n
);
  import etsc_pkg::*;

  logic pin_level;
  logic pin_rise;
  logic ev_det;
  logic high_det;
  logic high_clear;
  logic event_clear;
  logic resync;
  logic [7:0] hund_r;
  logic [31:0] pre_r;
  logic tick_r;
  logic high_flag_r;
  logic low_flag_r;
  logic ev_flag_r;
  logic sync_en_r;
  logic ev_clr_bit_r;
  logic irq_n_r;
  logic [2:0] por_cnt_r;
  logic por_done_r;
  logic por_clear;
  etsc_time_t cap_time;

  // ---------------------------------------------------------------
  // event pin
  // ---------------------------------------------------------------
  etsc_edge_det u_pin (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_external_event_pin),
    .o_level(pin_level),
    .o_rise(pin_rise)
  );

  // no enable bit; the backup supply state and the power-on sample window silence it
  assign ev_det = pin_rise && !i_backup_supply_state && por_done_r;

  // ---------------------------------------------------------------
  // power-on clear of the event bank, pin sampled after release
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      por_cnt_r <= 3'h0;
      por_done_r <= 1'b0;
    end else if (!por_done_r) begin
      por_cnt_r <= por_cnt_r + 3'h1;
      por_done_r <= (por_cnt_r == 3'(ETSC_POR_SAMPLE_CYC - 1));
    end
  end

  assign por_clear = !por_done_r && (por_cnt_r == 3'(ETSC_POR_SAMPLE_CYC - 1))
                     && pin_level;

  // ---------------------------------------------------------------
  // clear strobes
  // ---------------------------------------------------------------
  // every write of one clears, a held one does nothing more
  assign event_clear = (i_event_stamp_clear_wr && i_event_stamp_clear_val) || por_clear;
  assign high_clear = i_high_stamp_clear_wr;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ev_clr_bit_r <= 1'b0;
    end else if (i_event_stamp_clear_wr) begin
      ev_clr_bit_r <= i_event_stamp_clear_val;
    end
  end

  // ---------------------------------------------------------------
  // high temperature detect
  // ---------------------------------------------------------------
  assign high_det = i_meas_done && !i_stop
                    && (i_temp[ETSC_TEMP_HI:ETSC_TEMP_LO] > i_high_threshold);

  // ---------------------------------------------------------------
  // hundredths prescaler and second tick
  // ---------------------------------------------------------------
  // stamp takes the old hundredths, which are zeroed on the same edge
  assign resync = i_seconds_wr || (ev_det && sync_en_r);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      pre_r <= 32'h0;
      hund_r <= ETSC_ZERO_BYTE;
      tick_r <= 1'b0;
    end else if (i_stop || resync) begin
      // prescaler restarts; any pending tick is dropped
      pre_r <= 32'h0;
      hund_r <= ETSC_ZERO_BYTE;
      tick_r <= 1'b0;
    end else if (pre_r == 32'(HUNDREDTH_CYC - 1)) begin
      pre_r <= 32'h0;
      if (hund_r == 8'(ETSC_HUNDREDTHS_PER_S - 1)) begin
        hund_r <= ETSC_ZERO_BYTE;
        tick_r <= 1'b1;
      end else begin
        hund_r <= hund_r + ETSC_ONE_BYTE;
        tick_r <= 1'b0;
      end
    end else begin
      pre_r <= pre_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  always_comb begin
    cap_time = i_time;
    cap_time.hundredths = hund_r;
  end

  // ---------------------------------------------------------------
  // banks
  // ---------------------------------------------------------------
  etsc_stamp_bank #(
    .COUNT_ONLY_FIRST(1'b0)
  ) u_high (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_event(high_det && i_high_stamp_enable),
    .i_overwrite(i_high_stamp_overwrite),
    .i_block(i_high_bank_rd),
    .i_clear(high_clear),
    .i_time(cap_time),
    .o_bank(o_high_bank)
  );

  etsc_stamp_bank #(
    .COUNT_ONLY_FIRST(1'b1)
  ) u_event (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_event(ev_det),
    .i_overwrite(i_event_stamp_overwrite),
    .i_block(i_event_bank_rd),
    .i_clear(event_clear),
    .i_time(cap_time),
    .o_bank(o_event_bank)
  );

  // ---------------------------------------------------------------
  // flags; a set in the same cycle as a clear wins
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      high_flag_r <= 1'b0;
    end else if (high_det && i_high_stamp_enable) begin
      high_flag_r <= 1'b1;
    end else if (i_status_wr || high_clear || i_high_flag_clr) begin
      high_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      low_flag_r <= 1'b0;
    end else if (i_low_temp_event) begin
      low_flag_r <= 1'b1;
    end else if (i_status_wr) begin
      low_flag_r <= 1'b0;
    end
  end

  // the stamp clear is deliberately not among the clear terms
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ev_flag_r <= 1'b0;
    end else if (ev_det) begin
      ev_flag_r <= 1'b1;
    end else if (i_event_flag_clr) begin
      ev_flag_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // sync enable, cleared by hardware after its event
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sync_en_r <= 1'b0;
    end else if (ev_det && sync_en_r) begin
      sync_en_r <= 1'b0;
    end else if (i_event_sync_enable_wr) begin
      sync_en_r <= i_event_sync_enable_val;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= !(ev_flag_r && i_event_irq_enable);
    end
  end

  assign o_hundredths = hund_r;
  assign o_high_temp_flag = high_flag_r;
  assign o_low_temp_flag = low_flag_r;
  assign o_external_event_flag = ev_flag_r;
  assign o_event_sync_enable = sync_en_r;
  assign o_event_stamp_clear = ev_clr_bit_r;
  assign o_high_stamp_clear = 1'b0;
  assign o_second_tick = tick_r;
  assign o_irq_n = irq_n_r;
endmodule
`default_nettype wire

/* test/etsc_evt_src.sv */
/*
  external event source: one high pulse on the event pin per request.
  assumes requests are spaced wider than the pulse; idle level is low.
*/
`timescale 1ns/1ps
`default_nettype none
module etsc_evt_src (
  input wire logic i_go,
  output logic o_pin
);
  initial o_pin = 1'b0;
  // sixteen clock periods high so the synchroniser sees one clean rise
  always @(posedge i_go) begin
    o_pin = 1'b1;
    #400;
    o_pin = 1'b0;
  end
endmodule
`default_nettype wire

/* test/etsc_top_bench.sv */
/*
  self-checking bench for etsc_top: high bank table, then flags, clears,
  event bank first/last, wrap, sync and backup. assumes the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module etsc_top_bench;
  import etsc_pkg::*;
  localparam int HC = 4;
  typedef struct packed {
    logic [7:0] top; logic en; logic ow; logic rd; logic [7:0] cnt; logic [7:0] yr;
  } etsc_row_t;
  // year stamped is row index plus one
  etsc_row_t rows [7] = '{'{8'h50, 1, 0, 0, 8'h01, 8'h01}, '{8'h50, 1, 0, 0, 8'h02, 8'h01},
    '{8'h40, 1, 0, 0, 8'h02, 8'h01}, '{8'h50, 1, 1, 0, 8'h03, 8'h04},
    '{8'h50, 1, 1, 1, 8'h04, 8'h04}, '{8'h50, 0, 1, 0, 8'h04, 8'h04},
    '{8'h41, 1, 1, 0, 8'h05, 8'h07}};
  logic clk, rst_n, stop, sec_wr, meas, hen, how, hclr, hrd, low_ev, st_wr, efc, pin, go;
  logic bkp, eow, eclr, erd, syn_wr, event_irq_enable, hflag, lflag, eflag, syn, eclr_rb, hclr_rb, tick;
  logic irq_n;
  logic [11:0] temp;
  logic [7:0] hund;
  etsc_time_t tm;
  etsc_bank_t hb, eb;
  int num_errors = 0;
  int n_compared = 0;
  etsc_top #(.HUNDREDTH_CYC(HC)) etsc_top_inst (.i_ref_clk(clk), .i_rst_n(rst_n), .i_time(tm),
    .i_stop(stop), .i_seconds_wr(sec_wr), .i_meas_done(meas), .i_temp(temp),
    .i_high_threshold(8'h40), .i_high_stamp_enable(hen), .i_high_stamp_overwrite(how),
    .i_high_stamp_clear_wr(hclr), .i_high_bank_rd(hrd), .i_low_temp_event(low_ev),
    .i_status_wr(st_wr), .i_high_flag_clr(1'b0), .i_event_flag_clr(efc),
    .i_external_event_pin(pin), .i_backup_supply_state(bkp), .i_event_stamp_overwrite(eow),
    .i_event_stamp_clear_wr(eclr), .i_event_stamp_clear_val(1'b1), .i_event_bank_rd(erd),
    .i_event_sync_enable_wr(syn_wr), .i_event_sync_enable_val(1'b1), .i_event_irq_enable(event_irq_enable),
    .o_high_bank(hb), .o_event_bank(eb), .o_hundredths(hund), .o_high_temp_flag(hflag),
    .o_low_temp_flag(lflag), .o_external_event_flag(eflag), .o_event_sync_enable(syn),
    .o_event_stamp_clear(eclr_rb), .o_high_stamp_clear(hclr_rb), .o_second_tick(tick),
    .o_irq_n(irq_n));
  etsc_evt_src etsc_evt_src_inst (.i_go(go), .o_pin(pin));
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // wide enough for a whole bank plus the status bits packed beside it
  task automatic chk(input string nm, input logic [127:0] ex, input logic [127:0] got);
    n_compared++;
    if (got !== ex) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic pulse_hi(input logic [7:0] top);
    temp = {top, 4'h0};
    meas = 1'b1;
    cyc(1);
    meas = 1'b0;
    cyc(1);
  endtask
  // pin pulse lasts 16 clocks; 40 leaves it low long enough before the next
  task automatic ev();
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    cyc(40);
  endtask
  task automatic close_out();
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // --------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------
  initial begin
    {rst_n, stop, sec_wr, meas, hen, how, hclr, hrd, low_ev, st_wr, efc, go} = '0;
    {bkp, eow, eclr, erd, syn_wr, event_irq_enable} = '0;
    temp = '0;
    tm = '0;
    cyc(12);
    rst_n = 1'b1;
    cyc(6);
    foreach (rows[k]) begin
      tm.year = 8'(k + 1);
      {hen, how, hrd} = {rows[k].en, rows[k].ow, rows[k].rd};
      pulse_hi(rows[k].top);
      chk("high count", rows[k].cnt, hb.count);
      chk("high year", rows[k].yr, hb.stamp.year);
    end
    {hen, hrd} = 2'b10;
    chk("high flag", 1, hflag);
    low_ev = 1'b1;
    cyc(1);
    {low_ev, st_wr} = 2'b01;
    cyc(1);
    st_wr = 1'b0;
    cyc(1);
    chk("status flags", 0, {hflag, lflag});
    pulse_hi(8'h50);
    hclr = 1'b1;
    cyc(1);
    hclr = 1'b0;
    cyc(1);
    chk("high clear", 0, {hb, hflag, hclr_rb});
    {how, tm.year} = {1'b0, 8'h30};
    pulse_hi(8'h50);
    chk("high first", 8'h30, hb.stamp.year);
    stop = 1'b1;
    cyc(3);
    chk("hund stop", 0, hund);
    stop = 1'b0;
    cyc(3);
    sec_wr = 1'b1;
    cyc(1);
    sec_wr = 1'b0;
    chk("hund sec", 0, hund);
    // a full second of hundredths after the resync edge, no earlier tick
    cyc(399);
    chk("tick early", 0, tick);
    cyc(1);
    chk("tick", 1, tick);
    efc = 1'b1;
    cyc(1);
    {efc, eclr} = 2'b01;
    cyc(1);
    {eclr, event_irq_enable, tm.year} = {2'b01, 8'h20};
    ev();
    chk("ev stamp", {8'h01, 8'h20, 1'b0}, {eb.count, eb.stamp.year, irq_n});
    tm.year = 8'h21;
    ev();
    chk("ev first", 8'h20, eb.stamp.year);
    eow = 1'b1;
    ev();
    chk("ev last", 8'h21, eb.stamp.year);
    {erd, tm.year} = {1'b1, 8'h22};
    ev();
    erd = 1'b0;
    chk("ev blocked", {8'h04, 8'h21}, {eb.count, eb.stamp.year});
    eclr = 1'b1;
    cyc(1);
    eclr = 1'b0;
    cyc(1);
    chk("ev clear", {64'h0, 2'b11}, {eb, eflag, eclr_rb});
    {eow, tm.year} = {1'b0, 8'h23};
    ev();
    tm.year = 8'h24;
    repeat (255) ev();
    chk("ev wrap", {8'h00, 8'h23}, {eb.count, eb.stamp.year});
    ev();
    chk("ev rearm", {8'h01, 8'h24}, {eb.count, eb.stamp.year});
    syn_wr = 1'b1;
    cyc(1);
    syn_wr = 1'b0;
    cyc(1);
    chk("sync on", 1, syn);
    ev();
    chk("sync off", 0, syn);
    bkp = 1'b1;
    cyc(2);
    ev();
    chk("backup", 8'h02, eb.count);
    bkp = 1'b0;
    close_out();
  end
  // the sequence needs about 11200 clocks
  initial begin
    cyc(30000);
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire

/* test/etsc_top_sva.sv */
/*
  checker for etsc_top: ties the strobes at the inputs to the banks, flags and irq.
  assumes it is bound to etsc_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module etsc_top_sva #(
  parameter int HUNDREDTH_CYC = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_stop,
  input wire logic i_seconds_wr,
  input wire logic i_meas_done,
  input wire logic i_high_stamp_enable,
  input wire logic i_high_stamp_clear_wr,
  input wire logic i_low_temp_event,
  input wire logic i_status_wr,
  input wire logic i_backup_supply_state,
  input wire logic i_event_stamp_clear_wr,
  input wire logic i_event_irq_enable,
  input wire etsc_pkg::etsc_bank_t o_high_bank,
  input wire etsc_pkg::etsc_bank_t o_event_bank,
  input wire logic [7:0] o_hundredths,
  input wire logic o_high_temp_flag,
  input wire logic o_low_temp_flag,
  input wire logic o_external_event_flag,
  input wire logic o_event_sync_enable,
  input wire logic o_high_stamp_clear,
  input wire logic o_second_tick,
  input wire logic o_irq_n
);
  import etsc_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // --------------------------------------------------------------
  // event steps
  // --------------------------------------------------------------
  // a counter step that no clear caused is a detected external event
  sequence ev_counted;
    $changed(o_event_bank.count) && !$past(i_event_stamp_clear_wr);
  endsequence
  high_clr_zero_a: assert property (o_high_stamp_clear == 1'b0)
    else $error("high clear bit reads one");
  high_clr_bank_a: assert property (i_high_stamp_clear_wr && !i_meas_done |=>
    o_high_bank == ETSC_BANK_CLEAR && !o_high_temp_flag) else $error("high bank not cleared");
  status_clr_a: assert property (i_status_wr && !i_low_temp_event |=> !o_low_temp_flag)
    else $error("low flag survives status write");
  stop_hold_a: assert property (i_stop |=> o_hundredths == 8'h00 && !o_second_tick)
    else $error("time runs while stopped");
  sec_resync_a: assert property (i_seconds_wr |=> o_hundredths == 8'h00 && !o_second_tick)
    else $error("seconds write did not resync");
  ev_count_a: assert property (ev_counted |->
    o_event_bank.count == 8'($past(o_event_bank.count) + 8'h01)) else $error("event count step");
  sync_order_a: assert property (ev_counted |-> $past(o_event_sync_enable) == 1'b0 ||
    (!o_event_sync_enable && o_hundredths == 8'h00)) else $error("sync not dropped");
  ev_flag_a: assert property (ev_counted |-> o_external_event_flag)
    else $error("event flag not set");
  irq_off_a: assert property (!o_external_event_flag || !i_event_irq_enable |=> o_irq_n)
    else $error("irq without enabled flag");
  irq_on_a: assert property (o_external_event_flag && i_event_irq_enable |=> !o_irq_n)
    else $error("irq missing");
  backup_off_a: assert property (i_backup_supply_state[*5] ##0 !i_event_stamp_clear_wr
    |=> $stable(o_event_bank.count)) else $error("event counted in backup");
  high_gate_a: assert property (!i_high_stamp_enable && !i_high_stamp_clear_wr
    |=> $stable(o_high_bank.count)) else $error("high count while disabled");
endmodule
bind etsc_top etsc_top_sva #(.HUNDREDTH_CYC(HUNDREDTH_CYC)) etsc_top_sva_inst (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_stop(i_stop), .i_seconds_wr(i_seconds_wr),
  .i_meas_done(i_meas_done), .i_high_stamp_enable(i_high_stamp_enable),
  .i_high_stamp_clear_wr(i_high_stamp_clear_wr), .i_low_temp_event(i_low_temp_event),
  .i_status_wr(i_status_wr), .i_backup_supply_state(i_backup_supply_state),
  .i_event_stamp_clear_wr(i_event_stamp_clear_wr), .i_event_irq_enable(i_event_irq_enable),
  .o_high_bank(o_high_bank), .o_event_bank(o_event_bank), .o_hundredths(o_hundredths),
  .o_high_temp_flag(o_high_temp_flag), .o_low_temp_flag(o_low_temp_flag),
  .o_external_event_flag(o_external_event_flag), .o_event_sync_enable(o_event_sync_enable),
  .o_high_stamp_clear(o_high_stamp_clear), .o_second_tick(o_second_tick), .o_irq_n(o_irq_n));
`default_nettype wire
